// ==== common/trig_seq_pkg.sv ====
// Package: register map, source encodings, reset values and responses for the trigger sequencer
package trig_seq_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_COUNT  = 8'h04;
    localparam logic [7:0] OFF_CMD    = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_READS  = 8'h10;
    // Source encodings, 3 bits each
    localparam logic [2:0] SRC_AUTO  = 3'h0;
    localparam logic [2:0] SRC_EXT   = 3'h1;
    localparam logic [2:0] SRC_LINE  = 3'h2;
    localparam logic [2:0] SRC_LEVEL = 3'h3;
    localparam logic [2:0] SRC_SHOT  = 3'h4;
    localparam logic [2:0] SRC_DREQ  = 3'h5;
    localparam logic [2:0] SRC_HOLD  = 3'h6;
    // CTRL field positions
    localparam int ARM_LSB   = 0;
    localparam int TRIG_LSB  = 4;
    localparam int SAMP_LSB  = 8;
    localparam int MODE_BIT  = 12;
    localparam int MEMEN_BIT = 13;
    // CMD bits
    localparam int CMD_ARM_BIT  = 0;
    localparam int CMD_TRIG_BIT = 1;
    localparam int CMD_DREQ_BIT = 2;
    // Reset values
    localparam logic [31:0] CTRL_RST  = 32'h0000_0666;
    localparam logic [15:0] COUNT_RST = 16'h0001;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== src/edge_sync.sv ====
// Two-flop synchroniser with falling and rising edge pulse outputs
`timescale 1ns/1ns
`default_nettype none
module edge_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic din,
    output logic      fall,
    output logic      rise
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // Only sync_q reads meta_q
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign fall = last_q & ~sync_q;
    assign rise = ~last_q & sync_q;
endmodule
`default_nettype wire

// ==== src/measurement_trigger_sequencer.sv ====
// Trigger arm, trigger and sample sequencer with an AXI4-Lite register port
// Summary of operation
// - Ext-edge arm then line trigger: edge, zero crossing, then samples.
// - Ext arm, request trigger and sample: one request meets both stages.
// - Ext arm, request trigger, line/level sample: edge, request, samples.
// - Hold arm source: no readings until arm source changes.
// - Hold trigger source with live arm source: no readings at all.
// - One-shot arm, auto trigger: readings after arm command, then hold.
// - One-shot arm, ext trigger: command, edge, readings, then hold.
// - One-shot arm, level trigger: command, level event, readings, hold.
// - One-shot arm, line trigger: command, zero crossing, readings, hold.
// - Level event on set slope; level trigger or sample source only in DC or direct mode.
// - Data request counts only with output buffer empty and, with memory enabled, memory empty.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module measurement_trigger_sequencer #(
    parameter int CNT_W = 16
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ext_trig_pin,
    input  wire logic        line_zero_pin,
    input  wire logic        level_cross_pin,
    input  wire logic        out_buf_empty,
    input  wire logic        mem_empty,
    output logic             take_reading
);
    // Elaboration check: counter width the logic can serve
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
        $error("CNT_W must lie between 2 and 16");
    end

    // ==========================================================
    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARM  = 4'b0010,
        ST_TRIG = 4'b0100,
        ST_SAMP = 4'b1000
    } seq_e;

    seq_e             state_q;
    seq_e             state_d;
    logic [31:0]      ctrl_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] reads_q;
    logic             shot_q;
    logic             dreq_q;
    logic             done_q;
    logic             level_err_q;

    // ==========================================================
    // Pin synchronisers
    logic ext_fall;
    logic line_rise;
    logic lvl_rise;
    logic lvl_fall;
    logic ln_fall_unused;
    logic ext_rise_unused;

    edge_sync u_ext (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (ext_trig_pin),
        .fall    (ext_fall),
        .rise    (ext_rise_unused)
    );
    edge_sync u_line (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (line_zero_pin),
        .fall    (ln_fall_unused),
        .rise    (line_rise)
    );
    edge_sync u_lvl (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (level_cross_pin),
        .fall    (lvl_fall),
        .rise    (lvl_rise)
    );

    // ==========================================================
    // Field decode
    wire [2:0] arm_src   = ctrl_q[trig_seq_pkg::ARM_LSB +: 3];
    wire [2:0] trig_src  = ctrl_q[trig_seq_pkg::TRIG_LSB +: 3];
    wire [2:0] samp_src  = ctrl_q[trig_seq_pkg::SAMP_LSB +: 3];
    wire       dc_mode   = ctrl_q[trig_seq_pkg::MODE_BIT];
    wire       mem_en    = ctrl_q[trig_seq_pkg::MEMEN_BIT];
    wire       lvl_slope = ctrl_q[14];

    // Level slope chosen in software; comparator lives outside
    wire level_evt = dc_mode & (lvl_slope ? lvl_fall : lvl_rise);
    // Request ignored while readings wait to leave
    wire dreq_ok = dreq_q & out_buf_empty
                 & (~mem_en | mem_empty);

    // Event of the selected source; hold never fires
    function automatic logic src_hit(input logic [2:0] src,
                                     input logic ext, input logic line,
                                     input logic lvl, input logic shot,
                                     input logic dreq);
        unique case (src)
            trig_seq_pkg::SRC_AUTO:  src_hit = 1'b1;
            trig_seq_pkg::SRC_EXT:   src_hit = ext;
            trig_seq_pkg::SRC_LINE:  src_hit = line;
            trig_seq_pkg::SRC_LEVEL: src_hit = lvl;
            trig_seq_pkg::SRC_SHOT:  src_hit = shot;
            trig_seq_pkg::SRC_DREQ:  src_hit = dreq;
            default:                 src_hit = 1'b0;
        endcase
    endfunction

    wire arm_hit  = src_hit(arm_src, ext_fall, line_rise, level_evt,
                            shot_q, dreq_ok);
    wire trig_hit = src_hit(trig_src, ext_fall, line_rise, level_evt,
                            shot_q, dreq_ok);
    wire samp_hit = src_hit(samp_src, ext_fall, line_rise, level_evt,
                            shot_q, dreq_ok);
    // One request may satisfy trigger and sample together
    wire share    = (trig_src == trig_seq_pkg::SRC_DREQ)
                  & (samp_src == trig_seq_pkg::SRC_DREQ);
    wire last_rd  = (reads_q + 1'b1) == count_q;
    wire shot_arm = arm_src == trig_seq_pkg::SRC_SHOT;

    // ==========================================================
    // Sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: state_d = ST_ARM;
            ST_ARM:  if (arm_hit) begin
                state_d = ST_TRIG;
            end
            ST_TRIG: if (trig_hit) begin
                state_d = ST_SAMP;
            end
            ST_SAMP: if (samp_hit && last_rd) begin
                state_d = ST_ARM;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    wire samp_now = (state_q == ST_SAMP) & samp_hit;
    wire trig_now = (state_q == ST_TRIG) & trig_hit & share;
    wire rd_now   = samp_now | trig_now;
    wire finish   = rd_now & last_rd;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            reads_q <= '0;
            take_reading <= 1'b0;
            done_q <= 1'b0;
        end else begin
            // New settings restart the sequence from the arm stage
            if ((wr_ctrl && !lvl_bad) || (trig_now && last_rd)) begin
                state_q <= ST_ARM;
            end else begin
                state_q <= state_d;
            end
            take_reading <= rd_now;
            // Kept after the sequence so software can read the total
            if (state_q == ST_ARM && arm_hit) begin
                reads_q <= '0;
            end else if (rd_now) begin
                reads_q <= reads_q + 1'b1;
            end
            if (finish) begin
                done_q <= 1'b1;
            end else if (arm_hit && state_q == ST_ARM) begin
                done_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    logic       aw_hold_q;
    logic       w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire have_aw = aw_hold_q | aw_take;
    wire have_w  = w_hold_q | w_take;
    wire [7:0]  wa = aw_take ? s_axi_awaddr : awaddr_q;
    wire [31:0] wd = w_take ? s_axi_wdata : wdata_q;
    wire [3:0]  ws = w_take ? s_axi_wstrb : wstrb_q;
    wire do_wr   = have_aw & have_w & ~s_axi_bvalid;
    wire wr_ctrl = do_wr & (wa == trig_seq_pkg::OFF_CTRL);
    wire wr_cnt  = do_wr & (wa == trig_seq_pkg::OFF_COUNT);
    wire wr_cmd  = do_wr & (wa == trig_seq_pkg::OFF_CMD);
    wire wr_ok   = wr_ctrl | wr_cnt | wr_cmd;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    wire [31:0] ctrl_new = merge(ctrl_q, wd, ws);
    // Level trigger or sample source refused outside DC or direct modes
    wire lvl_bad = ~ctrl_new[trig_seq_pkg::MODE_BIT]
        & ((ctrl_new[trig_seq_pkg::TRIG_LSB +: 3] == trig_seq_pkg::SRC_LEVEL)
        |  (ctrl_new[trig_seq_pkg::SAMP_LSB +: 3]
            == trig_seq_pkg::SRC_LEVEL));
    wire [31:0] cnt_new = merge({{(32-CNT_W){1'b0}}, count_q}, wd, ws);
    wire cmd_arm  = wr_cmd & ws[0] & wd[trig_seq_pkg::CMD_ARM_BIT];
    wire cmd_dreq = wr_cmd & ws[0] & wd[trig_seq_pkg::CMD_DREQ_BIT];

    wire [31:0] status_w = {24'h00_0000, level_err_q, done_q,
                            dreq_q, shot_q, state_q};
    wire [31:0] rd_mux =
        (s_axi_araddr == trig_seq_pkg::OFF_CTRL)   ? ctrl_q :
        (s_axi_araddr == trig_seq_pkg::OFF_COUNT)  ?
            {{(32-CNT_W){1'b0}}, count_q} :
        (s_axi_araddr == trig_seq_pkg::OFF_STATUS) ? status_w :
        (s_axi_araddr == trig_seq_pkg::OFF_READS)  ?
            {{(32-CNT_W){1'b0}}, reads_q} : 32'h0000_0000;
    wire rd_ok = (s_axi_araddr == trig_seq_pkg::OFF_CTRL)
               | (s_axi_araddr == trig_seq_pkg::OFF_COUNT)
               | (s_axi_araddr == trig_seq_pkg::OFF_STATUS)
               | (s_axi_araddr == trig_seq_pkg::OFF_READS)
               | (s_axi_araddr == trig_seq_pkg::OFF_CMD);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= trig_seq_pkg::RESP_OKAY;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            s_axi_awready <= ~have_aw & ~s_axi_awready;
            s_axi_wready  <= ~have_w & ~s_axi_wready;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            aw_hold_q <= have_aw & ~do_wr;
            w_hold_q  <= have_w & ~do_wr;
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_ok && !(wr_ctrl && lvl_bad))
                              ? trig_seq_pkg::RESP_OKAY
                              : trig_seq_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= trig_seq_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid
                           & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_ok ? trig_seq_pkg::RESP_OKAY
                                      : trig_seq_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Control and command registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q      <= trig_seq_pkg::CTRL_RST;
            count_q     <= CNT_W'(trig_seq_pkg::COUNT_RST);
            shot_q      <= 1'b0;
            dreq_q      <= 1'b0;
            level_err_q <= 1'b0;
        end else begin
            if (finish && shot_arm) begin
                ctrl_q[trig_seq_pkg::ARM_LSB +: 3] <=
                    trig_seq_pkg::SRC_HOLD;
            end else if (wr_ctrl && !lvl_bad) begin
                ctrl_q <= {17'h0_0000, ctrl_new[14:0]};
            end
            if (wr_ctrl) begin
                level_err_q <= lvl_bad;
            end
            if (wr_cnt && cnt_new[CNT_W-1:0] != '0) begin
                count_q <= cnt_new[CNT_W-1:0];
            end
            // Command pulses stay pending until consumed; set beats clear
            if (cmd_arm) begin
                shot_q <= 1'b1;
            end else if (arm_hit && state_q == ST_ARM) begin
                shot_q <= 1'b0;
            end
            if (cmd_dreq) begin
                dreq_q <= 1'b1;
            end else if (dreq_ok) begin
                dreq_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Checks
    a_hold_arm_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        (arm_src == trig_seq_pkg::SRC_HOLD && state_q == ST_ARM)
        |=> state_q != ST_TRIG)
        else $error("arm stage left while arm source is hold");
    a_hold_trig_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        (trig_src == trig_seq_pkg::SRC_HOLD && state_q == ST_TRIG)
        |=> !take_reading)
        else $error("reading taken while trigger source is hold");
    a_shot_reverts: assert property (@(posedge aclk) disable iff (!aresetn)
        (finish && shot_arm) |=>
        arm_src == trig_seq_pkg::SRC_HOLD)
        else $error("one-shot arm did not revert to hold");
    a_count_limit: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == ST_SAMP) |-> reads_q < count_q)
        else $error("reading counter passed configured count");
    a_read_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_now |=> take_reading ##1 (reads_q != 0 || state_q == ST_ARM))
        else $error("reading pulse not followed by count");
    a_dreq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (dreq_q && !out_buf_empty) |=> dreq_q)
        else $error("data request consumed with output buffer busy");
    a_level_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        (trig_src == trig_seq_pkg::SRC_LEVEL) |-> dc_mode)
        else $error("level source set outside DC mode");
    a_share_one: assert property (@(posedge aclk) disable iff (!aresetn)
        trig_now |=> take_reading && $past(dreq_ok))
        else $error("shared request did not yield a reading");
endmodule
`default_nettype wire

// ==== tb/axi_host.sv ====
// Register bus host model that issues commands and data requests
`timescale 1ns/1ns
`default_nettype none
module axi_host (
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // ==========================================
    // Idle bus
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end
    // ==========================================
    // Transfers
    // Command ends with the write, no text terminator follows
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== tb/measurement_trigger_sequencer_tb_top.sv ====
// Testbench for the trigger sequencer: bus tasks and event scenarios
`timescale 1ns/1ns
`default_nettype none
module measurement_trigger_sequencer_tb_top;
    logic        aclk, aresetn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, take_reading;
    logic        ext_trig_pin, line_zero_pin, level_cross_pin;
    logic        out_buf_empty, mem_empty;
    logic [2:0]  trg [4];
    int          pn [4];
    int          fail_count, tests_run, n_rd;

    measurement_trigger_sequencer u_measurement_trigger_sequencer (.*);
    axi_host u_axi_host (.*);

    initial aclk = 1'b0;
    always #5 aclk = ~aclk;
    always @(posedge aclk) if (take_reading === 1'b1) n_rd <= n_rd + 1;

    // ==========================================
    // Helpers
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function logic [31:0] cfg(input logic [2:0] a, t, s, input logic m);
        cfg = 32'h0000_0000;
        cfg[trig_seq_pkg::ARM_LSB +: 3] = a;
        cfg[trig_seq_pkg::TRIG_LSB +: 3] = t;
        cfg[trig_seq_pkg::SAMP_LSB +: 3] = s;
        cfg[trig_seq_pkg::MODE_BIT] = m;
    endfunction
    // Parks in hold first so a half-written setup never fires
    task setup(input logic [2:0] a, t, s, input logic m, input int c);
        u_axi_host.wr(trig_seq_pkg::OFF_CTRL, trig_seq_pkg::CTRL_RST, rs);
        u_axi_host.wr(trig_seq_pkg::OFF_COUNT, 32'(c), rs);
        n_rd = 0;
        u_axi_host.wr(trig_seq_pkg::OFF_CTRL, cfg(a, t, s, m), rs);
    endtask
    task cmd(input int b);
        u_axi_host.wr(trig_seq_pkg::OFF_CMD, 32'h0000_0001 << b, rs);
    endtask
    task idle(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // 0 outside edge (falling), 1 zero crossing, 2 level crossing
    task pin_ev(input int k);
        @(posedge aclk);
        if (k == 0) ext_trig_pin <= 1'b0;
        else if (k == 1) line_zero_pin <= 1'b1;
        else level_cross_pin <= 1'b1;
        idle(4);
        ext_trig_pin <= 1'b1;
        line_zero_pin <= 1'b0;
        level_cross_pin <= 1'b0;
        idle(8);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        finish_test;
    end

    // ==========================================
    // Scenarios
    initial begin
        aresetn = 1'b0;
        ext_trig_pin = 1'b1;
        {line_zero_pin, level_cross_pin} = 2'h0;
        {out_buf_empty, mem_empty} = 2'h3;
        {n_rd, fail_count, tests_run} = '0;
        trg = '{trig_seq_pkg::SRC_AUTO, trig_seq_pkg::SRC_EXT,
                trig_seq_pkg::SRC_LEVEL, trig_seq_pkg::SRC_LINE};
        pn = '{0, 0, 2, 1};
        idle(6);
        aresetn <= 1'b1;
        u_axi_host.rd(trig_seq_pkg::OFF_CTRL, rv, rs);
        check(rv, trig_seq_pkg::CTRL_RST);
        u_axi_host.rd(trig_seq_pkg::OFF_COUNT, rv, rs);
        check(rv, {16'h0000, trig_seq_pkg::COUNT_RST});
        u_axi_host.rd(8'h40, rv, rs);
        check({30'h0, rs}, {30'h0, trig_seq_pkg::RESP_SLVERR});
        setup(trig_seq_pkg::SRC_HOLD, 3'h0, 3'h0, 1'b0, 3);
        pin_ev(0);
        pin_ev(1);
        idle(20);
        check(n_rd, 0);
        setup(3'h0, trig_seq_pkg::SRC_HOLD, 3'h0, 1'b0, 3);
        pin_ev(0);
        idle(20);
        check(n_rd, 0);
        setup(trig_seq_pkg::SRC_EXT, trig_seq_pkg::SRC_LINE,
              trig_seq_pkg::SRC_LINE, 1'b0, 3);
        pin_ev(1);
        check(n_rd, 0);
        pin_ev(0);
        repeat (5) pin_ev(1);
        check(n_rd, 3);
        u_axi_host.rd(trig_seq_pkg::OFF_READS, rv, rs);
        check(rv, 3);
        setup(trig_seq_pkg::SRC_EXT, trig_seq_pkg::SRC_DREQ,
              trig_seq_pkg::SRC_DREQ, 1'b0, 2);
        pin_ev(0);
        cmd(trig_seq_pkg::CMD_DREQ_BIT);
        idle(10);
        check(n_rd, 1);
        cmd(trig_seq_pkg::CMD_DREQ_BIT);
        idle(10);
        check(n_rd, 2);
        setup(trig_seq_pkg::SRC_EXT, trig_seq_pkg::SRC_DREQ,
              trig_seq_pkg::SRC_LEVEL, 1'b1, 2);
        pin_ev(0);
        pin_ev(2);
        cmd(trig_seq_pkg::CMD_DREQ_BIT);
        idle(10);
        check(n_rd, 0);
        repeat (3) pin_ev(2);
        check(n_rd, 2);
        // A refused request may be held; later scenarios avoid requests
        setup(trig_seq_pkg::SRC_EXT, trig_seq_pkg::SRC_DREQ,
              trig_seq_pkg::SRC_DREQ, 1'b0, 2);
        pin_ev(0);
        out_buf_empty <= 1'b0;
        cmd(trig_seq_pkg::CMD_DREQ_BIT);
        idle(10);
        check(n_rd, 0);
        out_buf_empty <= 1'b1;
        cmd(trig_seq_pkg::CMD_DREQ_BIT);
        idle(10);
        check(n_rd, 2);
        setup(trig_seq_pkg::SRC_HOLD, trig_seq_pkg::SRC_HOLD,
              trig_seq_pkg::SRC_HOLD, 1'b0, 1);
        u_axi_host.wr(trig_seq_pkg::OFF_CTRL, cfg(trig_seq_pkg::SRC_EXT,
                      trig_seq_pkg::SRC_LEVEL, 3'h0, 1'b0), rs);
        check({30'h0, rs}, {30'h0, trig_seq_pkg::RESP_SLVERR});
        u_axi_host.rd(trig_seq_pkg::OFF_CTRL, rv, rs);
        check(rv, trig_seq_pkg::CTRL_RST);
        u_axi_host.rd(trig_seq_pkg::OFF_STATUS, rv, rs);
        check({31'h0, rv[7]}, 1);
        for (int i = 0; i < 4; i++) begin
            setup(trig_seq_pkg::SRC_SHOT, trg[i], 3'h0, 1'b1, i + 2);
            idle(10);
            check(n_rd, 0);
            cmd(trig_seq_pkg::CMD_ARM_BIT);
            if (i > 0) begin
                idle(10);
                check(n_rd, 0);
                pin_ev(pn[i]);
            end
            idle(30);
            check(n_rd, i + 2);
            u_axi_host.rd(trig_seq_pkg::OFF_CTRL, rv, rs);
            check(rv[2:0], trig_seq_pkg::SRC_HOLD);
            u_axi_host.rd(trig_seq_pkg::OFF_READS, rv, rs);
            check(rv, i + 2);
        end
        finish_test;
    end
endmodule
`default_nettype wire
